// [hsgate_regs.vh]
// Purpose: Register offsets, fields, reset values and timing counts of the high-side gate gating block
// Assumes: Serial register port with a 10-bit word address and 16-bit data
// Notes:   Included by hsgate_top.v and hsgate_chan.v
`ifndef HSGATE_REGS_VH
`define HSGATE_REGS_VH

// ************************************************************
// Register offsets
// ************************************************************
`define HSG_ADDR_SLEW       10'h18E
`define HSG_ADDR_DRV_CFG    10'h1C5
`define HSG_ADDR_CLK_MON    10'h1C7
`define HSG_ADDR_HEALTH     10'h1D2

// ************************************************************
// Field positions
// ************************************************************
`define HSG_CFG_OVR5_BIT    0
`define HSG_CFG_BOOSTUV_BIT 1
`define HSG_CLK_SHUTOFF_BIT 0
`define HSG_ST_DRVEN_BIT    0
`define HSG_ST_GATEUV_BIT   1
`define HSG_ST_LOGICUV_BIT  2
`define HSG_ST_BOOSTUV_BIT  3
`define HSG_ST_CLKMISS_BIT  4
`define HSG_SLEW_W          2
`define HSG_NUM_CH          5

// ************************************************************
// Reset values
// ************************************************************
`define HSG_RST_SLEW        10'h000
`define HSG_RST_DRV_CFG     2'h0
`define HSG_RST_CLK_MON     1'h0

// ************************************************************
// Serial frame layout and timing
// ************************************************************
`define HSG_FRAME_BITS      6'h20
`define HSG_HDR_BITS        6'h10
`define HSG_FRM_WRITE_BIT   15
`define HSG_READY_TIME_US   300
`define HSG_CLK_MHZ         50
`define HSG_READY_CYCLES    (`HSG_READY_TIME_US * `HSG_CLK_MHZ)

`endif

// [hsgate_chan.v]
// Purpose: One high-side gate command cell
// Assumes: All qualifying inputs are levels already valid in the caller
// Notes:   Purely combinational so that any fault removes the command at once
`timescale 1ns/100ps
`include "hsgate_regs.vh"

module hsgate_chan
(
  input  wire       drive_enable_i,
  input  wire       enable_override_i,
  input  wire       gate_supply_undervoltage_i,
  input  wire       logic_supply_undervoltage_i,
  input  wire       boost_block_i,
  input  wire       clock_permit_i,
  input  wire       hold_off_i,
  input  wire       request_i,
  output wire       gate_cmd_o
);

  wire en_eff;

  assign en_eff = drive_enable_i | enable_override_i;  // R1 R4

  // Same path serves a low-side switch; nothing here depends on topology
  assign gate_cmd_o = en_eff                         // R8 R16 R17
                    & ~gate_supply_undervoltage_i    // R5
                    & ~logic_supply_undervoltage_i   // R5
                    & ~boost_block_i                 // R6
                    & clock_permit_i                 // R7
                    & ~hold_off_i                    // R3 R11
                    & request_i;                     // R9

endmodule

// [hsgate_top.v]
// Purpose: High-side gate command gating with serial register access
// Assumes: Serial port pins and enable pin are asynchronous to clk_sys_i
// Notes:   Gate commands are combinational; registers are reached only over the serial port
`timescale 1ns/100ps
`include "hsgate_regs.vh"

// Contract
// R1 - Enable pin low forces all gates off; core and serial port keep running. Channel 5 stays on while its override bit is set.
// R2 - Present enable pin level is readable in the health status register.
// R3 - Logic supply overvoltage shuts the device down and holds gates off.
// R4 - Override bit set makes channel 5 ignore the enable pin.
// R5 - Gate or logic supply undervoltage holds every gate command low.
// R6 - Boost undervoltage forces gates low when that shutoff is enabled.
// R7 - Missing clock forces gates low only if shutoff bit set; resets disabled.
// R8 - Command high only with enable, no undervoltage, clock permit and request.
// R9 - Channel requests come from the microcore logic channel outputs.
// R10 - Low command drives gate to power ground, high to gate supply.
// R11 - While power-on reset is low every gate is held off.
// R12 - Five independent identical channels, each with its own path.
// R13 - Each channel selects one of four slew pairs through registers.
// R14 - Host waits up to 300 us after reset release before trusting outputs.
// R15 - Host should check the serial port once readiness time has passed.
// R16 - Any channel may drive a low-side switch with identical gating.
// R17 - Gating is combinational so faults remove the command immediately.
module hsgate_top
#(
  parameter READY_CYCLES = `HSG_READY_CYCLES
)
(
  input  wire       clk_sys_i,
  input  wire       rst_i,
  input  wire       power_on_reset_n_i,
  input  wire       drive_enable_i,
  input  wire       gate_supply_undervoltage_i,
  input  wire       logic_supply_undervoltage_i,
  input  wire       boost_undervoltage_i,
  input  wire       logic_supply_overvoltage_i,
  input  wire       pll_unlocked_i,
  input  wire [4:0] channel_request_i,
  input  wire       spi_sclk_i,
  input  wire       spi_csb_i,
  input  wire       spi_mosi_i,
  output wire       spi_miso_o,
  output wire       spi_miso_oe_o,
  output wire [4:0] gate_cmd_o,
  output wire [4:0] gate_pull_up_o,
  output wire [4:0] gate_pull_down_o,
  output wire [9:0] slew_sel_o,
  output wire       ready_o
);

  // ************************************************************
  // Pin synchronisers: sclk, csb, mosi, enable
  // ************************************************************
  reg  [3:0]  s1_q;
  reg  [3:0]  s2_q;
  reg  [3:0]  s3_q;
  reg  [3:0]  lvl_q;
  wire [3:0]  pins;

  assign pins = {drive_enable_i, spi_mosi_i, spi_csb_i, spi_sclk_i};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_sync
      always @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          // Chip select idles high: every stage starts there, else a false select follows reset
          s1_q[g]  <= (g == 1) ? 1'b1 : 1'b0;
          s2_q[g]  <= (g == 1) ? 1'b1 : 1'b0;
          s3_q[g]  <= (g == 1) ? 1'b1 : 1'b0;
          lvl_q[g] <= (g == 1) ? 1'b1 : 1'b0;
        end
        else
        begin
          s1_q[g] <= pins[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g])
          begin
            lvl_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  reg  sclk_prev_q;
  wire sclk_rise;
  wire sclk_fall;
  wire csb_lvl;
  wire mosi_lvl;
  wire drven_lvl;

  assign csb_lvl   = lvl_q[1];
  assign mosi_lvl  = lvl_q[2];
  assign drven_lvl = lvl_q[3];
  assign sclk_rise = lvl_q[0] & ~sclk_prev_q & ~csb_lvl;
  assign sclk_fall = ~lvl_q[0] & sclk_prev_q & ~csb_lvl;

  // ************************************************************
  // Registers
  // ************************************************************
  reg  [9:0]  slew_q;
  reg  [1:0]  drv_cfg_q;
  reg         clk_shutoff_q;
  wire        core_rst;

  // Overvoltage resets the serial slave, registers and ready timer like rst_i; the pin synchronisers keep running
  assign core_rst = rst_i | logic_supply_overvoltage_i;  // R3

  // ************************************************************
  // Serial slave: 16-bit header {write, 5 spare, 10-bit address}, 16-bit data
  // ************************************************************
  reg  [5:0]  bit_cnt_q;
  reg  [15:0] hdr_q;
  reg  [15:0] din_q;
  reg  [15:0] dout_q;
  reg         miso_q;
  reg         rd_phase_q;
  reg  [15:0] rdata;
  wire [9:0]  addr;
  wire        wr_frame;
  wire        wr_done;

  assign addr     = hdr_q[9:0];
  assign wr_frame = hdr_q[`HSG_FRM_WRITE_BIT];
  assign wr_done  = sclk_rise & (bit_cnt_q == (`HSG_FRAME_BITS - 6'h01)) & wr_frame;

  // Read data mux, unmapped addresses read zero
  always @*
  begin
    rdata = 16'h0000;
    if (addr == `HSG_ADDR_SLEW)
    begin
      rdata = {6'h00, slew_q};
    end
    else if (addr == `HSG_ADDR_DRV_CFG)
    begin
      rdata = {14'h0000, drv_cfg_q};
    end
    else if (addr == `HSG_ADDR_CLK_MON)
    begin
      rdata = {15'h0000, clk_shutoff_q};
    end
    else if (addr == `HSG_ADDR_HEALTH)
    begin
      rdata = {11'h000, pll_unlocked_i, boost_undervoltage_i,
               logic_supply_undervoltage_i, gate_supply_undervoltage_i,
               drven_lvl};  // R2
    end
  end

  always @(posedge clk_sys_i)
  begin
    if (core_rst)
    begin
      sclk_prev_q <= 1'b0;
      bit_cnt_q   <= 6'h00;
      hdr_q       <= 16'h0000;
      din_q       <= 16'h0000;
      dout_q      <= 16'h0000;
      miso_q      <= 1'b0;
      rd_phase_q  <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= lvl_q[0];
      if (csb_lvl)
      begin
        // Deselect aborts any partial frame
        bit_cnt_q  <= 6'h00;
        rd_phase_q <= 1'b0;
      end
      else
      begin
        if (sclk_rise)
        begin
          if (bit_cnt_q < `HSG_HDR_BITS)
          begin
            hdr_q <= {hdr_q[14:0], mosi_lvl};
          end
          else
          begin
            din_q <= {din_q[14:0], mosi_lvl};
          end
          if (bit_cnt_q == (`HSG_HDR_BITS - 6'h01))
          begin
            rd_phase_q <= ~hdr_q[`HSG_FRM_WRITE_BIT - 1];
          end
          if (bit_cnt_q != `HSG_FRAME_BITS)
          begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
          end
        end
        if (sclk_fall)
        begin
          if (bit_cnt_q == `HSG_HDR_BITS)
          begin
            miso_q <= rdata[15];
            dout_q <= {rdata[14:0], 1'b0};
          end
          else
          begin
            miso_q <= dout_q[15];
            dout_q <= {dout_q[14:0], 1'b0};
          end
        end
      end
    end
  end

  // Register writes complete on the last rising clock of a write frame
  always @(posedge clk_sys_i)
  begin
    if (core_rst)
    begin
      slew_q        <= `HSG_RST_SLEW;
      drv_cfg_q     <= `HSG_RST_DRV_CFG;
      clk_shutoff_q <= `HSG_RST_CLK_MON;  // R7
    end
    else if (wr_done)
    begin
      if (addr == `HSG_ADDR_SLEW)
      begin
        slew_q <= {din_q[8:0], mosi_lvl};  // R13
      end
      else if (addr == `HSG_ADDR_DRV_CFG)
      begin
        drv_cfg_q <= {din_q[0], mosi_lvl};  // R4
      end
      else if (addr == `HSG_ADDR_CLK_MON)
      begin
        clk_shutoff_q <= mosi_lvl;  // R7
      end
    end
  end

  assign spi_miso_o    = miso_q;
  assign spi_miso_oe_o = ~csb_lvl & rd_phase_q;
  assign slew_sel_o    = slew_q;  // R13

  // ************************************************************
  // Readiness timer after reset release
  // ************************************************************
  reg  [15:0] rdy_cnt_q;
  reg         ready_q;

  always @(posedge clk_sys_i)
  begin
    if (core_rst | ~power_on_reset_n_i)
    begin
      rdy_cnt_q <= 16'h0000;
      ready_q   <= 1'b0;
    end
    else if (~ready_q)
    begin
      rdy_cnt_q <= rdy_cnt_q + 16'h0001;
      if (rdy_cnt_q == READY_CYCLES[15:0] - 16'h0001)
      begin
        ready_q <= 1'b1;  // R14
      end
    end
  end

  assign ready_o = ready_q;

  // ************************************************************
  // Gating, one cell per channel
  // ************************************************************
  wire clock_permit;
  wire boost_block;
  wire hold_off;

  // Enable pin, supplies and clock flag are used raw: no sync delay on shutoff
  assign clock_permit = ~(pll_unlocked_i & clk_shutoff_q);                 // R7
  assign boost_block  = boost_undervoltage_i & drv_cfg_q[`HSG_CFG_BOOSTUV_BIT];  // R6
  assign hold_off     = ~power_on_reset_n_i | logic_supply_overvoltage_i;   // R3 R11

  generate
    for (g = 0; g < `HSG_NUM_CH; g = g + 1)
    begin : g_chan
      hsgate_chan u_chan
      (
        .drive_enable_i              (drive_enable_i),
        .enable_override_i           ((g == 4) ? drv_cfg_q[`HSG_CFG_OVR5_BIT] : 1'b0),
        .gate_supply_undervoltage_i  (gate_supply_undervoltage_i),
        .logic_supply_undervoltage_i (logic_supply_undervoltage_i),
        .boost_block_i               (boost_block),
        .clock_permit_i              (clock_permit),
        .hold_off_i                  (hold_off),
        .request_i                   (channel_request_i[g]),
        .gate_cmd_o                  (gate_cmd_o[g])
      );  // R12 R9
      assign gate_pull_up_o[g]   = gate_cmd_o[g];   // R10
      assign gate_pull_down_o[g] = ~gate_cmd_o[g];  // R10 R11
    end
  endgenerate

endmodule

// [hsg_host.sv]
// Purpose: Serial host model driving the register port of the gate block
// Assumes: Mode 0, 32-bit frames, half period of 8 system clocks
// Notes:   Data line is inverted after a frame so stale bits never look valid
`timescale 1ns/100ps
module hsg_host
(
  input  wire  clk_sys_i,
  input  wire  spi_miso_i,
  output logic spi_sclk_o,
  output logic spi_csb_o,
  output logic spi_mosi_o
);
  initial
  begin
    spi_sclk_o = 1'b0;
    spi_csb_o  = 1'b1;
    spi_mosi_o = 1'b0;
  end
  // ****************************************
  // One frame: header then data, MSB first
  // ****************************************
  task automatic frame(input logic w, input logic [9:0] a, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    f = {w, 5'h00, a, wd};
    rd = 16'h0000;
    @(posedge clk_sys_i);
    spi_csb_o <= 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      spi_mosi_o <= f[i];
      repeat (8) @(posedge clk_sys_i);
      spi_sclk_o <= 1'b1;
      if (i < 16)
        rd[i] = spi_miso_i;
      repeat (8) @(posedge clk_sys_i);
      spi_sclk_o <= 1'b0;
    end
    repeat (8) @(posedge clk_sys_i);
    spi_csb_o  <= 1'b1;
    spi_mosi_o <= ~f[0];
    repeat (8) @(posedge clk_sys_i);
  endtask
endmodule

// [hsg_chk_assertions.sv]
// Purpose: Port-level checks of the gate command gating
// Assumes: Single clock domain, sync reset active high
// Notes:   Gating is combinational, so relations hold in the same cycle
`timescale 1ns/100ps
module hsg_chk
(
  input wire       clk_sys_i,
  input wire       rst_i,
  input wire       power_on_reset_n_i,
  input wire       drive_enable_i,
  input wire       gate_supply_undervoltage_i,
  input wire       logic_supply_undervoltage_i,
  input wire       boost_undervoltage_i,
  input wire       logic_supply_overvoltage_i,
  input wire       pll_unlocked_i,
  input wire [4:0] channel_request_i,
  input wire [4:0] gate_cmd_o,
  input wire [4:0] gate_pull_up_o,
  input wire [4:0] gate_pull_down_o,
  input wire [9:0] slew_sel_o,
  input wire       ready_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // ****************************************
  // Assertions
  // ****************************************
  a_enable_off: assert property (!drive_enable_i |-> gate_cmd_o[3:0] == 4'h0)
    else $error("gate on with enable low");
  a_supply_uv_off: assert property ((gate_supply_undervoltage_i || logic_supply_undervoltage_i) |-> gate_cmd_o == 5'h00)
    else $error("gate on during undervoltage");
  a_overvolt_off: assert property (logic_supply_overvoltage_i |-> gate_cmd_o == 5'h00)
    else $error("gate on during overvoltage");
  a_por_off: assert property (!power_on_reset_n_i |-> gate_cmd_o == 5'h00)
    else $error("gate on during power-on reset");
  a_request_only: assert property ((gate_cmd_o & ~channel_request_i) == 5'h00)
    else $error("gate on without request");
  a_drive_levels: assert property (gate_pull_up_o == gate_cmd_o && gate_pull_down_o == ~gate_cmd_o)
    else $error("pull drive disagrees with command");
  a_clean_follow: assert property ((drive_enable_i && !gate_supply_undervoltage_i && !logic_supply_undervoltage_i
    && !boost_undervoltage_i && !pll_unlocked_i && power_on_reset_n_i && !logic_supply_overvoltage_i)
    |-> gate_cmd_o == channel_request_i)
    else $error("command does not follow request");
  a_slew_reset: assert property ($fell(rst_i) |-> slew_sel_o == 10'h000)
    else $error("slew not cleared by reset");
  c_all_on: cover property (gate_cmd_o == 5'h1F);
  c_ovr_on: cover property (gate_cmd_o[4] && !drive_enable_i);
  c_ready: cover property ($rose(ready_o));
endmodule
bind hsgate_top hsg_chk chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .power_on_reset_n_i(power_on_reset_n_i),
  .drive_enable_i(drive_enable_i), .gate_supply_undervoltage_i(gate_supply_undervoltage_i),
  .logic_supply_undervoltage_i(logic_supply_undervoltage_i), .boost_undervoltage_i(boost_undervoltage_i),
  .logic_supply_overvoltage_i(logic_supply_overvoltage_i), .pll_unlocked_i(pll_unlocked_i),
  .channel_request_i(channel_request_i), .gate_cmd_o(gate_cmd_o), .gate_pull_up_o(gate_pull_up_o),
  .gate_pull_down_o(gate_pull_down_o), .slew_sel_o(slew_sel_o), .ready_o(ready_o));

// [tb.sv]
// Purpose: Self-checking bench for the gate command gating block
// Assumes: Ready time shortened to 20 clocks
// Notes:   Flags come from an LFSR seeded with 49
`timescale 1ns/100ps
`include "hsgate_regs.vh"
module tb;
  logic        clk_sys_i;
  logic        rst_i;
  logic        por_n, en, guv, luv, buv, ovv, pll, csh;
  logic [4:0]  req;
  logic [1:0]  cfg;
  logic [15:0] rdv, lfsr;
  int          fail_count, num_checks;
  wire         sclk, csb, mosi, miso, oe, ready;
  wire [4:0]   cmd;
  wire [9:0]   slew;
  // Undriven data line floats high through the board pull-up
  wire         miso_w = oe ? miso : 1'b1;
  hsgate_top #(.READY_CYCLES(20)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .power_on_reset_n_i(por_n),
    .drive_enable_i(en), .gate_supply_undervoltage_i(guv), .logic_supply_undervoltage_i(luv),
    .boost_undervoltage_i(buv), .logic_supply_overvoltage_i(ovv), .pll_unlocked_i(pll), .channel_request_i(req),
    .spi_sclk_i(sclk), .spi_csb_i(csb), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe), .gate_cmd_o(cmd),
    .gate_pull_up_o(), .gate_pull_down_o(), .slew_sel_o(slew), .ready_o(ready));
  hsg_host host (.clk_sys_i(clk_sys_i), .spi_miso_i(miso_w), .spi_sclk_o(sclk), .spi_csb_o(csb), .spi_mosi_o(mosi));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] nxt(input logic [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [4:0] exp_cmd(input logic [4:0] r);
    logic ok;
    ok = !guv && !luv && !(buv && cfg[1]) && !(pll && csh) && por_n && !ovv;
    exp_cmd = ok ? r & {en | cfg[0], {4{en}}} : 5'h00;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string m);
    num_checks++;
    if (got !== want)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, want);
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] want);
    host.frame(1'b0, a, 16'h0000, rdv);
    chk(rdv, want, "read");
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    host.frame(1'b1, a, d, rdv);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    #1_000_000;
    fail_count++;
    wrap_up;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst_i = 1'b1;
    por_n = 1'b1;
    en = 1'b1;
    {guv, luv, buv, ovv, pll, csh} = 6'h00;
    req = 5'h00;
    cfg = 2'h0;
    lfsr = 16'h0031;
    fail_count = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge clk_sys_i);
    chk({15'h0000, ready}, 16'h0001, "ready");
    rd(`HSG_ADDR_DRV_CFG, 16'h0000);
    rd(`HSG_ADDR_CLK_MON, 16'h0000);
    rd(`HSG_ADDR_SLEW, 16'h0000);
    rd(10'h3FF, 16'h0000);
    wr(`HSG_ADDR_SLEW, 16'h02D8);
    rd(`HSG_ADDR_SLEW, 16'h02D8);
    chk({6'h00, slew}, 16'h02D8, "slew");
    // Mid-run reset must clear the written slew and restart the ready timer
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (25) @(posedge clk_sys_i);
    chk({6'h00, slew}, 16'h0000, "slew reset");
    chk({15'h0000, ready}, 16'h0001, "ready again");
    for (int v = 0; v < 2; v++)
    begin
      en <= v[0];
      wr(`HSG_ADDR_HEALTH, 16'hFFFF);
      rd(`HSG_ADDR_HEALTH, {15'h0000, v[0]});
    end
    for (int c = 0; c < 8; c++)
    begin
      cfg = c[1:0];
      csh = c[2];
      wr(`HSG_ADDR_DRV_CFG, {14'h0000, cfg});
      wr(`HSG_ADDR_CLK_MON, {15'h0000, csh});
      repeat (40)
      begin
        lfsr = nxt(lfsr);
        @(posedge clk_sys_i);
        en <= lfsr[0] | lfsr[7];
        guv <= lfsr[1] & lfsr[8];
        luv <= lfsr[2] & lfsr[9];
        buv <= lfsr[3];
        pll <= lfsr[4];
        req <= lfsr[15:11];
        @(negedge clk_sys_i);
        chk({11'h000, cmd}, {11'h000, exp_cmd(req)}, "gate");
      end
    end
    @(posedge clk_sys_i);
    {guv, luv, buv, pll} <= 4'h0;
    req <= 5'h1F;
    en <= 1'b1;
    ovv <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk({11'h000, cmd}, 16'h0000, "overvoltage");
    chk({15'h0000, ready}, 16'h0000, "overvoltage ready");
    ovv <= 1'b0;
    por_n <= 1'b0;
    @(negedge clk_sys_i);
    chk({11'h000, cmd}, 16'h0000, "power-on");
    @(posedge clk_sys_i);
    por_n <= 1'b1;
    repeat (30) @(posedge clk_sys_i);
    rd(`HSG_ADDR_DRV_CFG, 16'h0000);
    en <= 1'b1;
    @(negedge clk_sys_i);
    chk({11'h000, cmd}, 16'h001F, "all on");
    wrap_up;
  end
endmodule
